// ---- pin_function_select.sv ----
// function select for the reset pin and port a bits 0 to 3
// assumes pad inputs and reset sources are synchronous to i_mclk
// and that a strobe is one cycle long, never read and write together
//
// Operation
// RULE1: after any reset every pin takes its primary function until software selects another.
// RULE2: a low reset pin puts the whole chip into reset and holds it there.
// RULE3: the chip reset ends on a clock edge a fixed number of clocks after the last source.
// RULE4: the reset pin used as gpio is an input or an open-drain output, never push-pull.
// RULE5: the reset pin used as gpio is no reset source; por, watchdog and software still are.
// RULE6: after reset the reset pin is back in its reset function.
// RULE7: each of port a bits 0 to 3 has its own direction, input or output.
// RULE8: with its alternate chosen, port a bit n drives modulator output n and is output only.
// RULE9: one select bit per pin resets to primary; pins switch in the cycle after a write.
`timescale 1ns/1ps
module pin_function_select (
    input  wire logic                             i_mclk,            // system clock
    input  wire logic                             i_rst,             // power-on, sync, high
    input  wire logic                             i_reset_pin_n,     // reset pad level
    input  wire logic                             i_watchdog_reset,  // watchdog reset, high
    input  wire logic [pin_mux_pkg::ADDR_W-1:0]   i_addr,            // register word address
    input  wire logic [pin_mux_pkg::DATA_W-1:0]   i_wdata,           // register write data
    input  wire logic                             i_wr,              // write strobe
    input  wire logic                             i_rd,              // read strobe
    output logic      [pin_mux_pkg::DATA_W-1:0]   o_rdata,           // read data, next cycle
    input  wire logic [pin_mux_pkg::PORT_A_BITS-1:0] i_modulator_out, // modulator outputs 0-3
    input  wire logic [pin_mux_pkg::PORT_A_BITS-1:0] i_port_a_bit_in, // port a pad levels
    output logic      [pin_mux_pkg::PORT_A_BITS-1:0] o_port_a_bit_out, // port a pad out
    output logic      [pin_mux_pkg::PORT_A_BITS-1:0] o_port_a_bit_oe,  // port a pad enable
    output logic      [pin_mux_pkg::PORT_A_BITS-1:0] o_port_a_pullup,  // port a pull-up on
    output logic                                  o_port_a_bit7_on_reset_pin_out, // pad out
    output logic                                  o_port_a_bit7_on_reset_pin_oe,  // pad enable
    output logic                                  o_reset_pin_pullup, // reset pad pull-up on
    output logic                                  o_chip_rst          // chip reset, high
);
    import pin_mux_pkg::*;

    // per-pin control, bit RESET_PIN_BIT is the reset pin
    logic [PIN_COUNT-1:0] func_sel_q;
    logic [PIN_COUNT-1:0] direction_q;
    logic [PIN_COUNT-1:0] data_out_q;
    logic [PIN_COUNT-1:0] data_out_d;
    logic [PIN_COUNT-1:0] pullup_q;
    logic [PIN_COUNT-1:0] pin_level_q;
    logic [CAUSE_W-1:0]   cause_q;
    logic [CAUSE_W-1:0]   cause_set;
    logic [CAUSE_W-1:0]   cause_clr;
    logic                 soft_req_q;
    logic                 pin_req;
    logic                 any_req;
    logic                 chip_rst;
    logic                 regs_clr;
    logic                 wr_ok;
    logic [DATA_W-1:0]    rdata_d;
    logic [DATA_W-1:0]    rdata_q;
    logic [PIN_COUNT-1:0] wr_bits;

    // the pin counts as reset only while its reset function is chosen
    assign pin_req = ~i_reset_pin_n & ~func_sel_q[RESET_PIN_BIT]; // RULE5

    // every source other than power-on, which the sequencer takes itself
    assign any_req = pin_req | i_watchdog_reset | soft_req_q; // RULE2

    reset_sequencer u_seq (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_req        (any_req),
        .o_rst_active (chip_rst)
    );

    assign o_chip_rst = chip_rst;

    // the block's own control is cleared by every reset of the chip
    assign regs_clr = i_rst | chip_rst;

    // writes during a chip reset are dropped, except the reset cause clear, so the reset state holds
    assign wr_ok   = i_wr & ~regs_clr;
    assign wr_bits = i_wdata[PIN_COUNT-1:0];

    // function select, zero means primary function for every pin
    always_ff @(posedge i_mclk) begin
        if (regs_clr) begin
            func_sel_q <= FUNC_SEL_RESET; // RULE1
        end else if (wr_ok && i_addr == OFS_FUNC_SEL) begin
            func_sel_q <= wr_bits; // RULE9
        end
    end

    // direction, one bit per pin, 1 selects output
    always_ff @(posedge i_mclk) begin
        if (regs_clr) begin
            direction_q <= DIRECTION_RESET;
        end else if (wr_ok && i_addr == OFS_DIRECTION) begin
            direction_q <= wr_bits; // RULE7
        end
    end

    // output data: plain write plus set, clear and toggle aliases
    // the aliases let software move one pin without a read-modify-write
    always_comb begin
        data_out_d = data_out_q;
        if (wr_ok) begin
            unique case (i_addr)
                OFS_DATA_OUT: data_out_d = wr_bits;
                OFS_DATA_SET: data_out_d = data_out_q | wr_bits;
                OFS_DATA_CLR: data_out_d = data_out_q & ~wr_bits;
                OFS_DATA_TGL: data_out_d = data_out_q ^ wr_bits;
                default:      data_out_d = data_out_q;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (regs_clr) begin
            data_out_q <= DATA_OUT_RESET;
        end else begin
            data_out_q <= data_out_d;
        end
    end

    // pull-ups stand on during and after reset, software may drop them
    always_ff @(posedge i_mclk) begin
        if (regs_clr) begin
            pullup_q <= PULLUP_RESET;
        end else if (wr_ok && i_addr == OFS_PULLUP_EN) begin
            pullup_q <= wr_bits;
        end
    end

    // pad levels sampled every cycle, readable in any function
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_level_q <= '0;
        end else begin
            pin_level_q <= {i_reset_pin_n, i_port_a_bit_in};
        end
    end

    // software reset request lives one cycle; the sequencer stretches it
    always_ff @(posedge i_mclk) begin
        if (regs_clr) begin
            soft_req_q <= 1'b0;
        end else begin
            soft_req_q <= wr_ok && i_addr == OFS_SOFT_RST && i_wdata[SOFT_RST_BIT];
        end
    end

    // reset cause: sticky, write one to clear, a new cause beats the clear
    assign cause_set[CAUSE_POR]      = 1'b0;
    assign cause_set[CAUSE_PIN]      = pin_req;
    assign cause_set[CAUSE_WATCHDOG] = i_watchdog_reset;
    assign cause_set[CAUSE_SOFTWARE] = soft_req_q;
    assign cause_clr = (i_wr && i_addr == OFS_RST_CAUSE) ? i_wdata[CAUSE_W-1:0] : '0;

    // of the resets only power-on reloads it, to the por cause alone, so software can see why it restarted
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cause_q <= CAUSE_RESET;
        end else begin
            cause_q <= (cause_q & ~cause_clr) | cause_set;
        end
    end

    // read mux, unmapped and write-only words read as zero
    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            unique case (i_addr)
                OFS_FUNC_SEL:  rdata_d[PIN_COUNT-1:0] = func_sel_q;
                OFS_DIRECTION: rdata_d[PIN_COUNT-1:0] = direction_q;
                OFS_DATA_OUT:  rdata_d[PIN_COUNT-1:0] = data_out_q;
                OFS_PIN_LEVEL: rdata_d[PIN_COUNT-1:0] = pin_level_q;
                OFS_PULLUP_EN: rdata_d[PIN_COUNT-1:0] = pullup_q;
                OFS_RST_CAUSE: rdata_d[CAUSE_W-1:0]   = cause_q;
                default:       rdata_d = '0;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // port a pads: gpio primary, modulator output as the alternate
    // registers feed the cells directly, so a write shows one edge later
    for (genvar n = 0; n < PORT_A_BITS; n++) begin : g_port_a
        pin_cell #(
            .OPEN_DRAIN (1'b0)
        ) u_cell (
            .i_alt_drive (func_sel_q[n]),  // RULE8
            .i_alt_out   (i_modulator_out[n]),
            .i_gpio_en   (~func_sel_q[n]), // RULE9
            .i_dir_out   (direction_q[n]),
            .i_data_out  (data_out_q[n]),
            .o_pad_out   (o_port_a_bit_out[n]),
            .o_pad_oe    (o_port_a_bit_oe[n])
        );
    end

    // reset pad: reset primary, open-drain gpio as the alternate
    pin_cell #(
        .OPEN_DRAIN (1'b1)
    ) u_reset_cell (
        .i_alt_drive (1'b0),
        .i_alt_out   (1'b0),
        .i_gpio_en   (func_sel_q[RESET_PIN_BIT]), // RULE6
        .i_dir_out   (direction_q[RESET_PIN_BIT]),
        .i_data_out  (data_out_q[RESET_PIN_BIT]),
        .o_pad_out   (o_port_a_bit7_on_reset_pin_out),
        .o_pad_oe    (o_port_a_bit7_on_reset_pin_oe) // RULE4
    );

    // pull-up only makes sense while the pad is not driven
    assign o_port_a_pullup    = pullup_q[PORT_A_BITS-1:0] & ~o_port_a_bit_oe;
    assign o_reset_pin_pullup = pullup_q[RESET_PIN_BIT] & ~o_port_a_bit7_on_reset_pin_oe;

endmodule

// ---- pin_mux_pkg.sv ----
// constants for the reset pin and port a pin function select block
// assumes a 16-bit register port with 4-bit word addresses
package pin_mux_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // number of pins handled: four port a bits plus the reset pin
    localparam int unsigned PORT_A_BITS = 4;
    localparam int unsigned PIN_COUNT   = 5;

    // bit position of the reset pin inside the per-pin registers
    localparam int unsigned RESET_PIN_BIT = 4;

    // register word offsets
    localparam logic [ADDR_W-1:0] OFS_FUNC_SEL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_DATA_OUT  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PULLUP_EN = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RST_CAUSE = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_SOFT_RST  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_DATA_SET  = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_DATA_CLR  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_DATA_TGL  = 4'h9;

    // values after reset
    localparam logic [PIN_COUNT-1:0] FUNC_SEL_RESET  = 5'h00;
    localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 5'h00;
    localparam logic [PIN_COUNT-1:0] DATA_OUT_RESET  = 5'h00;
    localparam logic [PIN_COUNT-1:0] PULLUP_RESET    = 5'h1f;

    // reset cause bit positions
    localparam int unsigned CAUSE_POR      = 0;
    localparam int unsigned CAUSE_PIN      = 1;
    localparam int unsigned CAUSE_WATCHDOG = 2;
    localparam int unsigned CAUSE_SOFTWARE = 3;
    localparam int unsigned CAUSE_W        = 4;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 4'h1;

    // bit of the soft reset register that requests a reset
    localparam int unsigned SOFT_RST_BIT = 0;

    // internal clocks the chip reset is held after the last source drops
    localparam int unsigned          RST_CNT_W            = 6;
    localparam logic [RST_CNT_W-1:0] RESET_RELEASE_CYCLES = 6'h20;
    localparam logic [RST_CNT_W-1:0] RST_CNT_ONE          = 6'h01;

endpackage

// ---- reset_sequencer.sv ----
// stretches any reset request into a chip reset held a fixed number of clocks after it
// assumes requests are synchronous to i_mclk
`timescale 1ns/1ps
module reset_sequencer (
    input  wire logic i_mclk,      // system clock
    input  wire logic i_rst,       // power-on reset, sync, active high
    input  wire logic i_req,       // any other qualified reset source
    output logic      o_rst_active // chip reset, active high
);
    import pin_mux_pkg::*;

    logic [RST_CNT_W-1:0] cnt_q;
    logic                 active_q;

    // reload while a source stands, count down once all sources drop
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_req) begin
            cnt_q <= RESET_RELEASE_CYCLES; // RULE3
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - RST_CNT_ONE;
        end
    end

    // release lands on a clock edge, never on the source edge itself
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_req) begin
            active_q <= 1'b1; // RULE2
        end else if (cnt_q == RST_CNT_ONE) begin
            active_q <= 1'b0; // RULE3
        end
    end

    // combined so the chip is in reset in the same cycle as the request
    assign o_rst_active = active_q | i_rst | i_req;

endmodule

// ---- pin_cell.sv ----
// one pad driver: alternate output, gpio, or no drive at all
// assumes the pad wire is resolved outside from out and oe
`timescale 1ns/1ps
module pin_cell #(
    parameter bit OPEN_DRAIN = 1'b0 // 1: gpio output may only pull low
) (
    input  wire logic i_alt_drive, // alternate output function chosen
    input  wire logic i_alt_out,   // level from the alternate source
    input  wire logic i_gpio_en,   // gpio function chosen
    input  wire logic i_dir_out,   // gpio direction, 1 = output
    input  wire logic i_data_out,  // gpio output level
    output logic      o_pad_out,   // pad output level
    output logic      o_pad_oe     // pad output enable, high drives
);

    // alternate wins; it is output only, so enable is forced on
    always_comb begin
        o_pad_out = 1'b0;
        o_pad_oe  = 1'b0;
        if (i_alt_drive) begin
            o_pad_out = i_alt_out; // RULE8
            o_pad_oe  = 1'b1;      // RULE8
        end else if (i_gpio_en && OPEN_DRAIN) begin
            // only a low is ever driven; a high is left to the pull-up
            o_pad_out = 1'b0;                   // RULE4
            o_pad_oe  = i_dir_out & ~i_data_out; // RULE4
        end else if (i_gpio_en) begin
            o_pad_out = i_data_out;
            o_pad_oe  = i_dir_out; // RULE7
        end
    end

endmodule

// ---- pin_mux_props.sv ----
// checker for the pin select block, bound to every instance
// assumes one clock, i_mclk, and i_rst as its synchronous reset
`timescale 1ns/1ps
module pin_mux_props
    import pin_mux_pkg::*;
(
    input wire logic                   i_mclk, i_rst, i_reset_pin_n, i_watchdog_reset, i_wr,
    input wire logic [ADDR_W-1:0]      i_addr,
    input wire logic [DATA_W-1:0]      i_wdata,
    input wire logic [PORT_A_BITS-1:0] i_modulator_out, o_port_a_bit_out, o_port_a_bit_oe,
    input wire logic [PORT_A_BITS-1:0] o_port_a_pullup,
    input wire logic                   o_port_a_bit7_on_reset_pin_out,
    input wire logic                   o_port_a_bit7_on_reset_pin_oe, o_chip_rst
);
    logic [PIN_COUNT-1:0]   sel_q;
    logic [RST_CNT_W-1:0]   gap_q;
    logic [PORT_A_BITS-1:0] wd_lo, sel_lo;
    logic                   soft_q, req, wr_ok, dir_wr;
    // shadow of what the block should see as its reset sources
    assign wr_ok  = i_wr && !o_chip_rst;
    assign dir_wr = wr_ok && i_addr == OFS_DIRECTION;
    assign wd_lo  = i_wdata[PORT_A_BITS-1:0];
    assign sel_lo = sel_q[PORT_A_BITS-1:0];
    assign req    = i_rst || i_watchdog_reset || soft_q
                    || (!i_reset_pin_n && !sel_q[RESET_PIN_BIT]);
    // select shadow, cleared by chip reset; writes in reset are refused
    always_ff @(posedge i_mclk) begin
        if (o_chip_rst)
            sel_q <= '0;
        else if (wr_ok && i_addr == OFS_FUNC_SEL)
            sel_q <= i_wdata[PIN_COUNT-1:0];
    end
    // soft request lands one cycle after its write
    always_ff @(posedge i_mclk) begin
        soft_q <= wr_ok && i_addr == OFS_SOFT_RST && i_wdata[SOFT_RST_BIT] && !i_rst;
    end
    // cycles since the last request, saturating so it never wraps
    always_ff @(posedge i_mclk) begin
        if (req)
            gap_q <= '0;
        else if (gap_q != '1)
            gap_q <= gap_q + RST_CNT_ONE;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_held_clear;
        $past(o_chip_rst) |-> o_port_a_bit_oe == '0 && !o_port_a_bit7_on_reset_pin_oe
            && o_port_a_pullup == '1;
    endproperty
    a_held_clear: assert property (p_held_clear) else $error("pads not idle in reset");
    property p_pin_rst;
        !i_reset_pin_n && !sel_q[RESET_PIN_BIT] |-> o_chip_rst;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("low reset pad ignored");
    property p_hold;
        gap_q < RESET_RELEASE_CYCLES |-> o_chip_rst;
    endproperty
    a_hold: assert property (p_hold) else $error("chip reset ended early");
    property p_rel;
        gap_q >= RESET_RELEASE_CYCLES && !req |-> !o_chip_rst;
    endproperty
    a_rel: assert property (p_rel) else $error("chip reset held too long");
    property p_od_out;
        o_port_a_bit7_on_reset_pin_out == 1'b0;
    endproperty
    a_od_out: assert property (p_od_out) else $error("reset pad driven high");
    property p_od_en;
        o_port_a_bit7_on_reset_pin_oe |-> sel_q[RESET_PIN_BIT];
    endproperty
    a_od_en: assert property (p_od_en) else $error("reset pad driven in reset role");
    property p_gpio_pin;
        !$past(o_chip_rst) && sel_q[RESET_PIN_BIT] && !i_watchdog_reset && !soft_q
            |-> !o_chip_rst;
    endproperty
    a_gpio_pin: assert property (p_gpio_pin) else $error("gpio pad caused reset");
    property p_dir;
        $past(dir_wr) && sel_lo == '0 |-> o_port_a_bit_oe == $past(wd_lo);
    endproperty
    a_dir: assert property (p_dir) else $error("direction write not applied");
    property p_alt;
        (o_port_a_bit_oe & sel_lo) == sel_lo
            && (o_port_a_bit_out & sel_lo) == (i_modulator_out & sel_lo);
    endproperty
    a_alt: assert property (p_alt) else $error("modulator not on pad");
endmodule

bind pin_function_select pin_mux_props i_props (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_pin_n(i_reset_pin_n),
    .i_watchdog_reset(i_watchdog_reset), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_modulator_out(i_modulator_out), .o_port_a_bit_out(o_port_a_bit_out),
    .o_port_a_bit_oe(o_port_a_bit_oe), .o_port_a_pullup(o_port_a_pullup),
    .o_port_a_bit7_on_reset_pin_out(o_port_a_bit7_on_reset_pin_out),
    .o_port_a_bit7_on_reset_pin_oe(o_port_a_bit7_on_reset_pin_oe), .o_chip_rst(o_chip_rst)
);

// ---- pad_board.sv ----
// board around the pads: pull-up on the reset pad, drivers on port a
// assumes pad out and enable come straight from the pin select block
`timescale 1ns/1ps
module pad_board (
    input  wire logic       i_mclk,    // system clock
    input  wire logic [3:0] i_a_out,   // port a pad out
    input  wire logic [3:0] i_a_oe,    // port a pad enable
    input  wire logic [3:0] i_a_pu,    // port a pull-up on
    input  wire logic [3:0] i_ext_en,  // board drives port a
    input  wire logic [3:0] i_ext_val, // board level on port a
    input  wire logic       i_rp_oe,   // device pulls reset pad low
    input  wire logic       i_rp_low,  // board pulls reset pad low
    output logic      [3:0] o_a_level, // resolved port a pads
    output logic            o_rp_level // resolved reset pad
);
    logic [3:0] last_q;
    // a floating pad flips each cycle so a stale level never looks valid
    always_ff @(posedge i_mclk) begin
        last_q <= o_a_level;
    end
    // device drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (i_a_oe[i])
                o_a_level[i] = i_a_out[i];
            else if (i_ext_en[i])
                o_a_level[i] = i_ext_val[i];
            else
                o_a_level[i] = i_a_pu[i] | ~last_q[i];
        end
    end
    // wired-and reset pad with a resistor to the supply
    assign o_rp_level = !(i_rp_oe || i_rp_low);
endmodule

// ---- tb_reset_and_port_a_pin_function_select.sv ----
// self-checking bench for the pin select block with a board model on the pads
// assumes the register map and reset length of pin_mux_pkg
`timescale 1ns/1ps
module tb_reset_and_port_a_pin_function_select;
    import pin_mux_pkg::*;
    logic              i_mclk, i_rst, i_watchdog_reset, i_wr, i_rd, rp_low;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic [3:0]        i_modulator_out, ext_en, ext_val, a_level, a_out, a_oe, a_pu;
    logic              rp_level, rp_out, rp_oe, rp_pu, o_chip_rst;
    int                n_fail = 0, tests_run = 0, cyc = 0, k;

    pin_function_select i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reset_pin_n(rp_level),
        .i_watchdog_reset(i_watchdog_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_modulator_out(i_modulator_out),
        .i_port_a_bit_in(a_level), .o_port_a_bit_out(a_out), .o_port_a_bit_oe(a_oe),
        .o_port_a_pullup(a_pu), .o_port_a_bit7_on_reset_pin_out(rp_out),
        .o_port_a_bit7_on_reset_pin_oe(rp_oe), .o_reset_pin_pullup(rp_pu),
        .o_chip_rst(o_chip_rst));
    pad_board i_board (.i_mclk(i_mclk), .i_a_out(a_out), .i_a_oe(a_oe), .i_a_pu(a_pu),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .i_rp_oe(rp_oe), .i_rp_low(rp_low),
        .o_a_level(a_level), .o_rp_level(rp_level));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic chk(input string nm, input logic [DATA_W-1:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle strobes, changed just after the edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk($sformatf("read %h", a), e, o_rdata);
    endtask
    // edges until the chip reset drops, bounded
    task automatic wait_low(output int n);
        n = 0;
        while (o_chip_rst !== 1'b0 && n < 100) begin
            @(posedge i_mclk);
            #1 n++;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        {i_rst, i_watchdog_reset, i_wr, i_rd, rp_low} = 5'b10000;
        {i_addr, i_wdata, i_modulator_out, ext_en, ext_val} = '0;
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1 wait_low(k);
        chk("por hold", RESET_RELEASE_CYCLES - RST_CNT_ONE, k[15:0]);
        chk("oe", 16'h0000, a_oe);
        chk("pad pullup", 16'h0001, rp_pu);
        chk("pullup", 16'h000f, a_pu);
        chk("pad oe", 16'h0000, rp_oe);
        rd(OFS_FUNC_SEL, 16'h0000);
        rd(OFS_PULLUP_EN, 16'h001f);
        rd(4'hf, 16'h0000);
        // gpio directions, other bits driven by the board
        ext_en <= 4'ha;
        ext_val <= 4'h8;
        wr(OFS_DATA_OUT, 16'h0003);
        wr(OFS_DIRECTION, 16'h0005);
        chk("oe", 16'h0005, a_oe);
        chk("out", 16'h0001, a_out & a_oe);
        chk("pullup", 16'h000a, a_pu);
        rd(OFS_PIN_LEVEL, 16'h0019);
        ext_en <= 4'h5;
        wr(OFS_DIRECTION, 16'h000a);
        chk("oe", 16'h000a, a_oe);
        wr(OFS_DIRECTION, 16'h0000);
        // each modulator output alone, both levels
        for (int n = 0; n < 4; n++) begin
            wr(OFS_FUNC_SEL, 16'h0001 << n);
            chk("alt oe", 16'h0001 << n, a_oe);
            for (int v = 0; v < 2; v++) begin
                @(posedge i_mclk);
                i_modulator_out <= {4{v[0]}};
                #1 chk("alt out", {15'h0000, v[0]}, {15'h0000, a_out[n]});
            end
        end
        // short low pulse on the reset pad
        @(posedge i_mclk);
        rp_low <= 1'b1;
        #1 chk("pad reset", 16'h0001, o_chip_rst);
        @(posedge i_mclk);
        rp_low <= 1'b0;
        #1 wait_low(k);
        chk("hold", RESET_RELEASE_CYCLES, k[15:0]);
        rd(OFS_FUNC_SEL, 16'h0000);
        // reset pad as open-drain gpio
        ext_en <= 4'hf;
        ext_val <= 4'h0;
        wr(OFS_FUNC_SEL, 16'h0010);
        wr(OFS_DIRECTION, 16'h0010);
        chk("od oe", 16'h0001, rp_oe);
        chk("pad pullup", 16'h0000, rp_pu);
        chk("od out", 16'h0000, rp_out);
        chk("no reset", 16'h0000, o_chip_rst);
        rd(OFS_PIN_LEVEL, 16'h0000);
        wr(OFS_DATA_OUT, 16'h0010);
        chk("od off", 16'h0000, rp_oe);
        rp_low <= 1'b1;
        rd(OFS_PIN_LEVEL, 16'h0000);
        chk("no reset", 16'h0000, o_chip_rst);
        rp_low <= 1'b0;
        // watchdog still resets and gives the pad back its reset role
        @(posedge i_mclk);
        i_watchdog_reset <= 1'b1;
        @(posedge i_mclk);
        i_watchdog_reset <= 1'b0;
        #1 chk("watchdog", 16'h0001, o_chip_rst);
        wait_low(k);
        chk("hold", RESET_RELEASE_CYCLES, k[15:0]);
        rd(OFS_FUNC_SEL, 16'h0000);
        // software reset; a write inside it is refused
        wr(OFS_SOFT_RST, 16'h0001);
        chk("soft", 16'h0001, o_chip_rst);
        wr(OFS_DIRECTION, 16'h000f);
        wait_low(k);
        chk("soft hold", RESET_RELEASE_CYCLES - RST_CNT_ONE, k[15:0]);
        rd(OFS_DIRECTION, 16'h0000);
        // set, clear and toggle aliases move only the data bits written as one
        wr(OFS_DATA_SET, 16'h0006);
        wr(OFS_DATA_CLR, 16'h0002);
        wr(OFS_DATA_TGL, 16'h0011);
        rd(OFS_DATA_OUT, 16'h0015);
        // every source above left its cause; write one clears them
        rd(OFS_RST_CAUSE, 16'h000f);
        wr(OFS_RST_CAUSE, 16'h000f);
        rd(OFS_RST_CAUSE, 16'h0000);
        final_report();
    end
endmodule
